//--- src/fdc_regs_pkg.sv
package fdc_regs_pkg;
   // register indices; byte address is four times the index
   localparam logic [9:0] IDX_OUTPUT = 10'h002; // digital_output_reg
   localparam logic [9:0] IDX_STATUS = 10'h004; // main_status_reg read, rate_precomp_select write
   localparam logic [9:0] IDX_DATA = 10'h005; // fifo_data_port
   localparam logic [9:0] IDX_DIAG = 10'h007; // drive_input_diagnostic read, rate_config_control write
   localparam logic [9:0] IDX_SETUP = 10'h008; // setup_command fields
   localparam logic [9:0] IDX_MODE = 10'h009; // mode fields
   localparam logic [9:0] IDX_PHASE = 10'h00A; // phase control and fifo state
   // reset values
   localparam logic [7:0] RATE_SEL_RST = 8'h02;
   localparam logic [1:0] RATE_CODE_RST = 2'h2;
   localparam logic [7:0] OUTPUT_RST = 8'h04;
   // field positions
   localparam int OUT_RESET_BIT = 2;
   localparam int SEL_RATE_LSB = 0;
   localparam int SEL_PRE_LSB = 2;
   localparam int SEL_LOWPWR_BIT = 6;
   localparam int SEL_SRST_BIT = 7;
   localparam int ST_REQ_BIT = 7;
   localparam int ST_DIR_BIT = 6;
   localparam int ST_NDMA_BIT = 5;
   localparam int ST_BUSY_BIT = 4;
   localparam int DIAG_CHG_BIT = 7;
   localparam int DIAG_LOW_BIT = 0;
   localparam logic [7:0] DIAG_ONES = 8'h78; // bits 6-3 read as one
   // rate codes
   localparam logic [1:0] RATE_1M = 2'h3;
   localparam logic [1:0] RATE_500K = 2'h0;
   localparam logic [2:0] PRE_DEFAULT = 3'h0;
   localparam logic [2:0] PRE_NONE = 3'h7;
   // timing, figures in picoseconds
   localparam int CLK_PS = 5000;
   localparam int PRE_STEP_PS = 41700;
   localparam int PRE_DEF_LOW_PS = 125000;
   localparam int PRE_DEF_1M_PS = 41700;
   localparam int SRST_PS = 100000;
   localparam int GAP_PS = 350000;
   localparam logic [4:0] SRST_CYC = 5'((SRST_PS + CLK_PS - 1) / CLK_PS);
   localparam logic [6:0] GAP_CYC = 7'((GAP_PS + CLK_PS - 1) / CLK_PS);
   localparam int LINE_LEN = 64;
   localparam int FIFO_DEPTH = 16;
   localparam logic [4:0] FIFO_FULL = 5'h10;
   localparam logic [4:0] BYTE_ONE = 5'h01;

   typedef enum logic [3:0] {
      PH_IDLE = 4'b0001,
      PH_CMD = 4'b0010,
      PH_EXEC = 4'b0100,
      PH_RESULT = 4'b1000
   } phase_t;

   typedef struct packed {
      logic [3:0] fifo_trigger_level;
      logic fifo_en;
      logic lock;
      logic [7:0] start_track;
   } setup_t;

   typedef struct packed {
      logic burst_en;
      logic rd_fifo_dis;
      logic wr_fifo_dis;
      logic at_mode;
   } mode_t;

   typedef struct packed {
      logic [7:0] data;
      logic valid;
   } byte_t;
endpackage : fdc_regs_pkg

//--- src/fdc_host_regs.sv
// The APB slave port was decided locally.
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - precomp field bits 4-2 delays write data; 000 default, 111 zero, else steps.
// - default precomp is 41.7 ns at 1 Mbps, 125 ns at other rates.
// - precomp starts at track zero; setup command changes the start track.
// - bit 6 of rate register or mode command enters manual power-down.
// - power-down ends on soft reset or data or status register access.
// - bit 7 of rate register soft-resets like output register bit, self-clears 100 ns.
// - data register at 05h carries command, data and result bytes.
// - 16-byte fifo used only in execution phase; bypassed in command, result.
// - setup command enables fifo and loads 4-bit trigger threshold.
// - locked and enabled fifo stays enabled across soft reset.
// - hardware reset disables fifo and zeroes its threshold.
// - mode command disables fifo for reads and writes separately.
// - burst mode keeps the request active until fifo emptied or filled.
// - non-burst mode drops the request 350 ns between transfers.
// - in AT drive mode only diagnostic bit 7 is driven.
// - alternate mode bit 0 reads 0 at high rates, 1 at low rates.
// - alternate mode bits 2,1 return the last written rate code.
// - alternate mode bits 6-3 read as one.
// - diagnostic bit 7 mirrors media-changed input, reads 0 in power-down; soft reset leaves it alone.
// - config register bits 1,0 set rate; hardware reset gives 10, soft keeps.
// - hardware reset loads rate register with 02h; soft reset keeps it.
module fdc_host_regs (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic disk_byte_valid,
   input wire logic [7:0] disk_byte_in,
   input wire logic disk_byte_ready,
   output logic [7:0] disk_byte_out,
   output logic disk_byte_out_valid,
   input wire logic [7:0] result_byte,
   output logic result_taken,
   output logic [7:0] cmd_byte,
   output logic cmd_strobe,
   output logic xfer_req,
   input wire logic media_changed_in,
   input wire logic wdata_in,
   input wire logic [7:0] current_track,
   output logic wdata_out,
   output logic soft_reset_active,
   output logic powered_down,
   output logic [1:0] rate_code
);

   typedef struct packed {
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
      logic [7:0] rate_sel;
      logic [1:0] rate;
      logic [7:0] out_reg;
      logic [4:0] srst_cnt;
      logic pd;
      fdc_regs_pkg::setup_t setup;
      fdc_regs_pkg::mode_t mode;
      fdc_regs_pkg::phase_t phase;
      logic exec_rd;
      logic dma_mode;
      logic [fdc_regs_pkg::FIFO_DEPTH-1:0][7:0] mem;
      logic [4:0] cnt;
      logic req;
      logic svc;
      logic [6:0] gap;
      fdc_regs_pkg::byte_t dsk_out;
      logic [7:0] cmd;
      logic cmd_stb;
      logic res_tk;
      logic rqm_hold;
      logic [fdc_regs_pkg::LINE_LEN-1:0] line;
      logic wout;
      logic chg_meta;
      logic chg;
      logic srst_o;
   } state_t;

   state_t s_q, s_d;

   // delay in cycles for a precomp figure, rounded to nearest
   function automatic logic [6:0] ps_to_cyc(input int ps);
      ps_to_cyc = 7'((ps + fdc_regs_pkg::CLK_PS / 2) / fdc_regs_pkg::CLK_PS);
   endfunction : ps_to_cyc

   function automatic logic [6:0] pre_cycles(input logic [2:0] code, input logic [1:0] rate);
      pre_cycles = 7'h00;
      if (code == fdc_regs_pkg::PRE_DEFAULT) begin
         pre_cycles = (rate == fdc_regs_pkg::RATE_1M) ? ps_to_cyc(fdc_regs_pkg::PRE_DEF_1M_PS)
                                                      : ps_to_cyc(fdc_regs_pkg::PRE_DEF_LOW_PS);
      end else if (code != fdc_regs_pkg::PRE_NONE) begin
         pre_cycles = ps_to_cyc(int'(code) * fdc_regs_pkg::PRE_STEP_PS);
      end
   endfunction : pre_cycles

   // byte count at which a request is raised
   function automatic logic trigger(input logic rd, input logic [4:0] cnt, input logic [4:0] thr,
                                    input logic [4:0] cap);
      if (rd) begin
         trigger = (cnt >= cap - thr) && (cnt != 5'h00);
      end else begin
         trigger = (cnt <= thr) && (cnt < cap);
      end
   endfunction : trigger

   logic access;
   logic [9:0] idx;
   logic [7:0] wbyte;
   logic srst;
   logic fifo_on;
   logic [4:0] cap;
   logic [4:0] thr_eff;
   logic host_pop;
   logic host_push;
   logic disk_push;
   logic disk_pop;
   logic [4:0] cnt_next;
   logic [7:0] sts;
   logic [7:0] diag;
   logic [6:0] tap;
   logic pre_on;

   always_comb begin
      s_d = s_q;
      // access phase in which the answer is given; writes act here
      access = psel && penable && s_q.pready;
      idx = paddr[11:2];
      wbyte = pwdata[7:0];
      // soft reset from output register or self-clearing rate bit
      srst = !s_q.out_reg[fdc_regs_pkg::OUT_RESET_BIT] || (s_q.srst_cnt != 5'h00);
      // fifo only for execution phase in the enabled direction
      fifo_on = s_q.setup.fifo_en && (s_q.phase == fdc_regs_pkg::PH_EXEC)
                && !(s_q.exec_rd ? s_q.mode.rd_fifo_dis : s_q.mode.wr_fifo_dis);
      cap = fifo_on ? fdc_regs_pkg::FIFO_FULL : fdc_regs_pkg::BYTE_ONE;
      // threshold taken as zero with the fifo off
      thr_eff = fifo_on ? {1'b0, s_q.setup.fifo_trigger_level} : 5'h00;

      // status and diagnostic read values
      sts = 8'h00;
      unique case (s_q.phase)
         fdc_regs_pkg::PH_IDLE: sts[fdc_regs_pkg::ST_REQ_BIT] = !s_q.rqm_hold;
         fdc_regs_pkg::PH_CMD: begin
            sts[fdc_regs_pkg::ST_REQ_BIT] = !s_q.rqm_hold;
            sts[fdc_regs_pkg::ST_BUSY_BIT] = 1'b1;
         end
         fdc_regs_pkg::PH_EXEC: begin
            sts[fdc_regs_pkg::ST_REQ_BIT] = s_q.req;
            sts[fdc_regs_pkg::ST_DIR_BIT] = s_q.exec_rd;
            sts[fdc_regs_pkg::ST_NDMA_BIT] = !s_q.dma_mode;
            sts[fdc_regs_pkg::ST_BUSY_BIT] = 1'b1;
         end
         fdc_regs_pkg::PH_RESULT: begin
            sts[fdc_regs_pkg::ST_REQ_BIT] = !s_q.rqm_hold;
            sts[fdc_regs_pkg::ST_DIR_BIT] = 1'b1;
            sts[fdc_regs_pkg::ST_BUSY_BIT] = 1'b1;
         end
      endcase
      // media-changed mirror, forced low while powered down
      diag = 8'h00;
      diag[fdc_regs_pkg::DIAG_CHG_BIT] = s_q.chg && !s_q.pd;
      if (!s_q.mode.at_mode) begin
         diag = diag | fdc_regs_pkg::DIAG_ONES;
         diag[2:1] = s_q.rate;
         diag[fdc_regs_pkg::DIAG_LOW_BIT] = (s_q.rate != fdc_regs_pkg::RATE_1M)
                                            && (s_q.rate != fdc_regs_pkg::RATE_500K);
      end
      // AT mode leaves bits 6-0 to the shared hard-disk register

      // no wait state: setup cycle prepares the answer, ready in the first access cycle
      s_d.pready = psel && !penable;
      s_d.pslverr = 1'b0;
      if (psel && !penable) begin
         s_d.prdata = 32'h0000_0000;
         s_d.pslverr = 1'b1;
         unique case (idx)
            fdc_regs_pkg::IDX_OUTPUT: begin
               s_d.prdata[7:0] = s_q.out_reg;
               s_d.pslverr = 1'b0;
            end
            fdc_regs_pkg::IDX_STATUS: begin
               s_d.prdata[7:0] = pwrite ? 8'h00 : sts;
               s_d.pslverr = 1'b0;
            end
            fdc_regs_pkg::IDX_DATA: begin
               // one data register for every phase
               s_d.prdata[7:0] = (s_q.phase == fdc_regs_pkg::PH_RESULT) ? result_byte :
                                 (s_q.cnt != 5'h00) ? s_q.mem[0] : 8'h00;
               s_d.pslverr = 1'b0;
            end
            fdc_regs_pkg::IDX_DIAG: begin
               s_d.prdata[7:0] = pwrite ? 8'h00 : diag;
               s_d.pslverr = 1'b0;
            end
            fdc_regs_pkg::IDX_SETUP: begin
               s_d.prdata[15:0] = {s_q.setup.start_track, 2'b00, s_q.setup.lock, s_q.setup.fifo_en,
                                   s_q.setup.fifo_trigger_level};
               s_d.pslverr = 1'b0;
            end
            fdc_regs_pkg::IDX_MODE: begin
               s_d.prdata[4:0] = {s_q.mode.at_mode, s_q.pd, s_q.mode.wr_fifo_dis, s_q.mode.rd_fifo_dis,
                                  s_q.mode.burst_en};
               s_d.pslverr = 1'b0;
            end
            fdc_regs_pkg::IDX_PHASE: begin
               s_d.prdata[17:0] = {srst, s_q.req, 3'b000, s_q.cnt, 2'b00, s_q.dma_mode, s_q.exec_rd,
                                   s_q.phase};
               s_d.pslverr = 1'b0;
            end
            default: s_d.prdata = 32'h0000_0000;
         endcase
      end

      // one-cycle strobes
      s_d.cmd_stb = 1'b0;
      s_d.res_tk = 1'b0;
      s_d.rqm_hold = 1'b0;
      s_d.dsk_out.valid = 1'b0;
      host_pop = 1'b0;
      host_push = 1'b0;
      if (s_q.srst_cnt != 5'h00) begin
         s_d.srst_cnt = s_q.srst_cnt - 5'h01;
      end

      // register writes and data-register side effects
      if (access) begin
         // data or status register access wakes the controller
         if (idx == fdc_regs_pkg::IDX_STATUS && !pwrite || idx == fdc_regs_pkg::IDX_DATA) begin
            s_d.pd = 1'b0;
         end
         unique case (idx)
            fdc_regs_pkg::IDX_OUTPUT: if (pwrite) s_d.out_reg = wbyte;
            fdc_regs_pkg::IDX_STATUS: if (pwrite) begin
               s_d.rate_sel = wbyte;
               s_d.rate_sel[fdc_regs_pkg::SEL_SRST_BIT] = 1'b0;
               s_d.rate = wbyte[fdc_regs_pkg::SEL_RATE_LSB +: 2];
               if (wbyte[fdc_regs_pkg::SEL_LOWPWR_BIT]) s_d.pd = 1'b1;
               if (wbyte[fdc_regs_pkg::SEL_SRST_BIT]) s_d.srst_cnt = fdc_regs_pkg::SRST_CYC;
            end
            fdc_regs_pkg::IDX_DATA: begin
               if (s_q.phase == fdc_regs_pkg::PH_CMD && pwrite) begin
                  s_d.cmd = wbyte;
                  s_d.cmd_stb = 1'b1;
                  s_d.rqm_hold = 1'b1;
               end else if (s_q.phase == fdc_regs_pkg::PH_RESULT && !pwrite) begin
                  s_d.res_tk = 1'b1;
                  s_d.rqm_hold = 1'b1;
               end else if (s_q.phase == fdc_regs_pkg::PH_EXEC && !s_q.pd) begin
                  host_pop = !pwrite && s_q.exec_rd && (s_q.cnt != 5'h00);
                  host_push = pwrite && !s_q.exec_rd && (s_q.cnt < cap);
               end
            end
            // config register sets rate; upper bits ignored
            fdc_regs_pkg::IDX_DIAG: if (pwrite) s_d.rate = wbyte[1:0];
            fdc_regs_pkg::IDX_SETUP: if (pwrite) begin
               s_d.setup.fifo_trigger_level = pwdata[3:0];
               s_d.setup.fifo_en = pwdata[4];
               s_d.setup.lock = pwdata[5];
               s_d.setup.start_track = pwdata[15:8];
            end
            fdc_regs_pkg::IDX_MODE: if (pwrite) begin
               s_d.mode.burst_en = pwdata[0];
               s_d.mode.rd_fifo_dis = pwdata[1];
               s_d.mode.wr_fifo_dis = pwdata[2];
               if (pwdata[3]) s_d.pd = 1'b1;
               s_d.mode.at_mode = pwdata[4];
            end
            fdc_regs_pkg::IDX_PHASE: if (pwrite) begin
               s_d.phase = fdc_regs_pkg::phase_t'(pwdata[3:0]);
               if (!$onehot(pwdata[3:0])) s_d.phase = fdc_regs_pkg::PH_IDLE;
               s_d.exec_rd = pwdata[4];
               s_d.dma_mode = pwdata[5];
            end
            default: s_d.pslverr = 1'b0;
         endcase
      end

      // disk side moves bytes only while awake and executing
      disk_push = !s_q.pd && (s_q.phase == fdc_regs_pkg::PH_EXEC) && s_q.exec_rd && disk_byte_valid
                  && (s_q.cnt < cap);
      disk_pop = !s_q.pd && (s_q.phase == fdc_regs_pkg::PH_EXEC) && !s_q.exec_rd && disk_byte_ready
                 && (s_q.cnt != 5'h00) && !host_push;
      if (host_pop || disk_pop) begin
         if (disk_pop) s_d.dsk_out = '{data: s_q.mem[0], valid: 1'b1};
         for (int i = 0; i < fdc_regs_pkg::FIFO_DEPTH - 1; i++) s_d.mem[i] = s_q.mem[i+1];
      end
      cnt_next = s_q.cnt - 5'((host_pop || disk_pop) ? 1 : 0);
      if (host_push || disk_push) begin
         s_d.mem[4'(cnt_next)] = host_push ? wbyte : disk_byte_in;
         cnt_next = cnt_next + 5'h01;
      end
      s_d.cnt = cnt_next;

      // transfer request pacing
      if (s_q.pd || s_q.phase != fdc_regs_pkg::PH_EXEC) begin
         s_d.req = 1'b0;
         s_d.svc = 1'b0;
         s_d.gap = 7'h00;
      end else if (s_q.req) begin
         if (host_pop || host_push) begin
            s_d.svc = s_q.exec_rd ? (cnt_next != 5'h00) : (cnt_next < cap);
            // burst holds the request while read bytes remain or write space remains
            if (s_q.mode.burst_en) begin
               s_d.req = s_d.svc;
            end else begin
               s_d.req = 1'b0;
               s_d.gap = fdc_regs_pkg::GAP_CYC;
            end
         end
      end else if (s_q.gap != 7'h00) begin
         s_d.gap = s_q.gap - 7'h01;
      end else if (trigger(s_q.exec_rd, s_q.cnt, thr_eff, cap)
                   || (s_q.svc && (s_q.exec_rd ? s_q.cnt != 5'h00 : s_q.cnt < cap))) begin
         s_d.req = 1'b1;
         s_d.svc = 1'b1;
      end

      // soft reset wins over phase, fifo count, request pacing, power-down and unlocked fifo enable
      if (srst) begin
         s_d.phase = fdc_regs_pkg::PH_IDLE;
         s_d.cnt = 5'h00;
         s_d.req = 1'b0;
         s_d.svc = 1'b0;
         s_d.gap = 7'h00;
         s_d.pd = 1'b0;
         s_d.setup.fifo_en = s_q.setup.fifo_en && s_q.setup.lock;
      end
      // flop copy, so the reset flag leaves on a register
      s_d.srst_o = (s_d.srst_cnt != 5'h00) || !s_d.out_reg[fdc_regs_pkg::OUT_RESET_BIT];

      // precomp applies from the start track onward
      s_d.line = {s_q.line[fdc_regs_pkg::LINE_LEN-2:0], wdata_in};
      pre_on = current_track >= s_q.setup.start_track;
      tap = pre_on ? pre_cycles(s_q.rate_sel[fdc_regs_pkg::SEL_PRE_LSB +: 3], s_q.rate) : 7'h00;
      s_d.wout = s_q.pd ? 1'b0 : (tap == 7'h00) ? wdata_in : s_q.line[6'(tap - 7'h01)];

      // two-stage synchroniser; the first stage feeds only the second
      s_d.chg_meta = media_changed_in;
      s_d.chg = s_q.chg_meta;
   end

   // single state register; hardware reset values
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_q <= '0;
         s_q.rate_sel <= fdc_regs_pkg::RATE_SEL_RST;
         s_q.rate <= fdc_regs_pkg::RATE_CODE_RST;
         s_q.out_reg <= fdc_regs_pkg::OUTPUT_RST;
         s_q.phase <= fdc_regs_pkg::PH_IDLE;
      end else begin
         s_q <= s_d;
      end
   end

   assign prdata = s_q.prdata;
   assign pready = s_q.pready;
   assign pslverr = s_q.pslverr;
   assign disk_byte_out = s_q.dsk_out.data;
   assign disk_byte_out_valid = s_q.dsk_out.valid;
   assign result_taken = s_q.res_tk;
   assign cmd_byte = s_q.cmd;
   assign cmd_strobe = s_q.cmd_stb;
   assign xfer_req = s_q.req;
   assign wdata_out = s_q.wout;
   assign soft_reset_active = s_q.srst_o;
   assign powered_down = s_q.pd;
   assign rate_code = s_q.rate;

endmodule : fdc_host_regs
`default_nettype wire

//--- tb/fdc_host_regs_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module fdc_host_regs_checker (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic cmd_strobe,
   input wire logic xfer_req,
   input wire logic soft_reset_active,
   input wire logic powered_down,
   input wire logic [1:0] rate_code
);
   logic acc;
   logic wr4;
   logic wr7;
   logic rd4;
   // completed accesses per register
   assign acc = psel && penable && pready;
   assign wr4 = acc && pwrite && paddr == 12'h010;
   assign wr7 = acc && pwrite && paddr == 12'h01C;
   assign rd4 = acc && !pwrite && paddr == 12'h010;
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   apb_answer_a: assert property (psel && !penable |=> pready) else $error("no answer after setup");
   err_ready_a: assert property (pslverr |-> pready) else $error("error without ready");
   rate_sel_a: assert property (wr4 |=> rate_code == $past(pwdata[1:0])) else $error("rate select ignored");
   rate_cfg_a: assert property (wr7 |=> rate_code == $past(pwdata[1:0])) else $error("rate config ignored");
   power_down_a: assert property (wr4 && pwdata[6] && !pwdata[7] |=> powered_down)
      else $error("no power down");
   power_wake_a: assert property (powered_down && rd4 |-> ##[1:2] !powered_down)
      else $error("no wake on status read");
   srst_clear_a: assert property (wr4 && pwdata[7] |=> soft_reset_active[*8] ##[10:14] !soft_reset_active)
      else $error("soft reset length wrong");
   diag_bits_a: assert property (acc && !pwrite && paddr == 12'h01C |->
      prdata[6:0] == 7'h00 || prdata[6:0] == {4'hF, rate_code, ^rate_code}) else $error("diagnostic bits wrong");
   reset_rate_a: assert property ($rose(presetn) |-> rate_code == 2'h2) else $error("reset rate wrong");
   cmd_strobe_a: assert property (cmd_strobe |-> $past(acc && pwrite && paddr == 12'h014))
      else $error("strobe without data write");
   soft_c: cover property (wr4 && pwdata[7]);
   pd_c: cover property ($rose(powered_down));
   req_c: cover property ($rose(xfer_req));
   err_c: cover property (pslverr);
endmodule : fdc_host_regs_checker
bind fdc_host_regs fdc_host_regs_checker fdc_host_regs_checker_inst (.pclk(pclk), .presetn(presetn),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .cmd_strobe(cmd_strobe), .xfer_req(xfer_req),
   .soft_reset_active(soft_reset_active), .powered_down(powered_down), .rate_code(rate_code));
`default_nettype wire

//--- tb/disk_side_model.sv
`timescale 1ns/1ps
`default_nettype none
module disk_side_model (
   input wire logic pclk,
   input wire logic accept,
   output logic disk_byte_valid,
   output logic [7:0] disk_byte_in,
   output logic disk_byte_ready
);
   // idle data is the inverse of the last byte, never a stale copy
   initial begin
      disk_byte_valid = 1'b0;
      disk_byte_in = 8'hFF;
   end
   // one byte, held for exactly one sampled cycle
   task push_byte(input logic [7:0] b);
      @(posedge pclk);
      disk_byte_valid <= 1'b1;
      disk_byte_in <= b;
      @(posedge pclk);
      disk_byte_valid <= 1'b0;
      disk_byte_in <= ~b;
   endtask : push_byte
   // drive takes bytes only when allowed, so it can stall
   always @(posedge pclk) begin
      disk_byte_ready <= accept;
   end
endmodule : disk_side_model
`default_nettype wire

//--- tb/fdc_host_regs_test.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin mismatches++; \
$display("MISMATCH %s exp %h got %h", nm, e, g); end end
module fdc_host_regs_test;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er, accept, media_changed_in, wdata_in;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic dvalid, dready, dout_valid, cmd_strobe, xfer_req, soft_reset_active, powered_down, wdata_out, result_taken;
   logic [7:0] din, dout, result_byte, cmd_byte, current_track;
   logic [1:0] rate_code;
   int mismatches, checks_done, n;
   fdc_host_regs fdc_host_regs_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .disk_byte_valid(dvalid), .disk_byte_in(din), .disk_byte_ready(dready), .disk_byte_out(dout),
      .disk_byte_out_valid(dout_valid), .result_byte(result_byte), .result_taken(result_taken), .cmd_byte(cmd_byte),
      .cmd_strobe(cmd_strobe), .xfer_req(xfer_req), .media_changed_in(media_changed_in), .wdata_in(wdata_in),
      .current_track(current_track), .wdata_out(wdata_out), .soft_reset_active(soft_reset_active),
      .powered_down(powered_down), .rate_code(rate_code));
   disk_side_model disk_side_model_inst (.pclk(pclk), .accept(accept), .disk_byte_valid(dvalid),
      .disk_byte_in(din), .disk_byte_ready(dready));
   initial begin
      pclk = 1'b0;
      forever #2.5 pclk = ~pclk;
   end
   // setup, then hold the access until ready is sampled
   task apb(input logic w, input logic [9:0] idx, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= {idx, 2'b00}; pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata; er = pslverr; psel <= 1'b0; penable <= 1'b0;
   endtask : apb
   task wr(input logic [9:0] idx, input logic [31:0] d);
      apb(1'b1, idx, d);
   endtask : wr
   task rdchk(input logic [9:0] idx, input logic [7:0] e, input string nm);
      apb(1'b0, idx, 32'h0);
      `CHK(nm, e, rd[7:0])
   endtask : rdchk
   // bounded wait on the request level; n holds the cycles spent
   task wait_req(input logic v);
      n = 0;
      while (xfer_req !== v && n < 200) begin @(negedge pclk); n++; end
   endtask : wait_req
   task t_reset_map;
      `CHK("rate", 2'h2, rate_code)
      rdchk(fdc_regs_pkg::IDX_SETUP, 8'h00, "setup");
      apb(1'b0, 10'h03F, 32'h0);
      `CHK("slverr", 1'b1, er)
      for (int c = 0; c < 8; c++) begin
         wr(c[2] ? fdc_regs_pkg::IDX_STATUS : fdc_regs_pkg::IDX_DIAG, 32'(c[1:0]));
         rdchk(fdc_regs_pkg::IDX_DIAG, {5'h0F, c[1:0], c[1] ^ c[0]}, "diag");
      end
      wr(fdc_regs_pkg::IDX_DIAG, 32'h2);
      media_changed_in <= 1'b1;
      repeat (4) @(posedge pclk);
      rdchk(fdc_regs_pkg::IDX_DIAG, 8'hFD, "chg");
      wr(fdc_regs_pkg::IDX_MODE, 32'h10);
      rdchk(fdc_regs_pkg::IDX_DIAG, 8'h80, "at");
      wr(fdc_regs_pkg::IDX_MODE, 32'h0);
      media_changed_in <= 1'b0;
   endtask : t_reset_map
   task t_soft;
      wr(fdc_regs_pkg::IDX_SETUP, 32'h0539);
      wr(fdc_regs_pkg::IDX_STATUS, 32'h81);
      wait_req(1'b0);
      n = 0;
      @(negedge pclk);
      while (soft_reset_active === 1'b1 && n < 40) begin @(negedge pclk); n++; end
      `CHK("srst_len", 20, n)
      rdchk(fdc_regs_pkg::IDX_SETUP, 8'h39, "lock");
      rdchk(fdc_regs_pkg::IDX_DIAG, 8'h7B, "rate_kept");
      wr(fdc_regs_pkg::IDX_SETUP, 32'h0019);
      wr(fdc_regs_pkg::IDX_OUTPUT, 32'h0);
      @(negedge pclk);
      `CHK("out_srst", 1'b1, soft_reset_active)
      wr(fdc_regs_pkg::IDX_OUTPUT, 32'h4);
      rdchk(fdc_regs_pkg::IDX_SETUP, 8'h09, "unlocked");
      wr(fdc_regs_pkg::IDX_STATUS, 32'h42);
      @(negedge pclk);
      `CHK("pd", 1'b1, powered_down)
      apb(1'b0, fdc_regs_pkg::IDX_STATUS, 32'h0);
      @(negedge pclk);
      `CHK("wake", 1'b0, powered_down)
      wr(fdc_regs_pkg::IDX_MODE, 32'h08);
      apb(1'b0, fdc_regs_pkg::IDX_DATA, 32'h0);
      @(negedge pclk);
      `CHK("wake_data", 1'b0, powered_down)
   endtask : t_soft
   task t_phases;
      wr(fdc_regs_pkg::IDX_PHASE, 32'h2);
      rdchk(fdc_regs_pkg::IDX_STATUS, 8'h90, "poll_cmd");
      wr(fdc_regs_pkg::IDX_DATA, 32'hA5);
      n = 0;
      while (cmd_strobe !== 1'b1 && n < 4) begin @(negedge pclk); n++; end
      `CHK("cmd", 8'hA5, cmd_byte)
      wr(fdc_regs_pkg::IDX_PHASE, 32'h8);
      result_byte <= 8'h3C;
      rdchk(fdc_regs_pkg::IDX_DATA, 8'h3C, "result");
      @(negedge pclk);
      `CHK("res_tk", 1'b1, result_taken)
      wr(fdc_regs_pkg::IDX_PHASE, 32'h14);
      disk_side_model_inst.push_byte(8'hA1);
      wait_req(1'b1);
      rdchk(fdc_regs_pkg::IDX_DATA, 8'hA1, "exec");
      disk_side_model_inst.push_byte(8'hA2);
      wait_req(1'b1);
      `CHK("gap", 1'b1, n >= 60 && n <= 75)
      rdchk(fdc_regs_pkg::IDX_DATA, 8'hA2, "exec2");
   endtask : t_phases
   task t_burst;
      wr(fdc_regs_pkg::IDX_SETUP, 32'h1F);
      wr(fdc_regs_pkg::IDX_MODE, 32'h1);
      for (int i = 0; i < 3; i++) disk_side_model_inst.push_byte(8'hB0 + 8'(i));
      wait_req(1'b1);
      rdchk(fdc_regs_pkg::IDX_DATA, 8'hB0, "b0");
      @(negedge pclk);
      `CHK("held", 1'b1, xfer_req)
      rdchk(fdc_regs_pkg::IDX_DATA, 8'hB1, "b1");
      rdchk(fdc_regs_pkg::IDX_DATA, 8'hB2, "b2");
      wait_req(1'b0);
      `CHK("drop", 1'b1, n < 5)
      wr(fdc_regs_pkg::IDX_PHASE, 32'h4);
      wr(fdc_regs_pkg::IDX_DATA, 32'h5A);
      accept <= 1'b1;
      n = 0;
      while (dout_valid !== 1'b1 && n < 20) begin @(negedge pclk); n++; end
      `CHK("wr_out", 8'h5A, dout)
   endtask : t_burst
   // pulse on write data; n counts cycles to its delayed copy
   task pc(input logic [7:0] sel, input int e, input string nm);
      wr(fdc_regs_pkg::IDX_STATUS, 32'(sel));
      wdata_in <= 1'b1;
      @(posedge pclk);
      wdata_in <= 1'b0;
      n = 0;
      while (wdata_out !== 1'b1 && n < 80) begin @(negedge pclk); n++; end
      `CHK(nm, e + 1, n)
   endtask : pc
   // longest tap first, so no old pulse meets a shorter tap
   task t_precomp;
      pc(8'h1A, 50, "pre6");
      pc(8'h02, 25, "pre_def");
      pc(8'h03, 8, "pre_1m");
      pc(8'h1E, 0, "pre_off");
      wr(fdc_regs_pkg::IDX_SETUP, 32'h0500);
      pc(8'h02, 0, "pre_trk");
   endtask : t_precomp
   task complete_run;
      $display("checks %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : complete_run
   initial begin
      {psel, penable, pwrite, paddr, pwdata, accept, media_changed_in, result_byte, wdata_in, current_track} = '0;
      mismatches = 0; checks_done = 0; presetn = 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      t_reset_map();
      t_soft();
      t_phases();
      t_burst();
      t_precomp();
      complete_run();
   end
   // hang guard, far beyond the expected run
   initial begin
      #100000;
      mismatches++;
      complete_run();
   end
endmodule : fdc_host_regs_test
`default_nettype wire
